// ===== rtl/rtck_pkg.sv
// constants shared by the timekeeping core and its crystal sensing front end
package rtck_pkg;
  // register addresses
  localparam logic [3:0] ADDR_SEC      = 4'h0;
  localparam logic [3:0] ADDR_MIN      = 4'h1;
  localparam logic [3:0] ADDR_HOUR     = 4'h2;
  localparam logic [3:0] ADDR_WEEKDAY  = 4'h3;
  localparam logic [3:0] ADDR_DAY      = 4'h4;
  localparam logic [3:0] ADDR_MONTH    = 4'h5;
  localparam logic [3:0] ADDR_YEAR     = 4'h6;
  localparam logic [3:0] ADDR_TRIM     = 4'h7;
  localparam logic [3:0] ADDR_ALA_MIN  = 4'h8;
  localparam logic [3:0] ADDR_ALA_HOUR = 4'h9;
  localparam logic [3:0] ADDR_ALA_WDAY = 4'ha;
  localparam logic [3:0] ADDR_ALB_MIN  = 4'hb;
  localparam logic [3:0] ADDR_ALB_HOUR = 4'hc;
  localparam logic [3:0] ADDR_ALB_WDAY = 4'hd;
  localparam logic [3:0] ADDR_CTRL_ONE = 4'he;
  localparam logic [3:0] ADDR_CTRL_TWO = 4'hf;

  // control_two field positions
  localparam int BIT_FMT24   = 5;
  localparam int BIT_ADJUST  = 4;
  localparam int BIT_CLKDIS  = 3;
  localparam int BIT_PERFLAG = 2;
  localparam int BIT_AFLAG   = 1;
  localparam int BIT_BFLAG   = 0;
  // control_one field positions
  localparam int BIT_AEN     = 7;
  localparam int BIT_BEN     = 6;
  localparam int BIT_ROUTEHI = 5;
  localparam int BIT_ROUTELO = 4;
  localparam int BIT_TEST    = 3;
  // trim register: crystal select on top of the trim value
  localparam int BIT_XSEL    = 7;
  // hour register pm indicator in 12-hour format
  localparam int BIT_PM      = 5;

  // reset values of the counters
  localparam logic [7:0] RST_SEC     = 8'h00;
  localparam logic [7:0] RST_MIN     = 8'h00;
  localparam logic [7:0] RST_HOUR    = 8'h12;
  localparam logic [2:0] RST_WEEKDAY = 3'h0;
  localparam logic [7:0] RST_DAY     = 8'h01;
  localparam logic [7:0] RST_MONTH   = 8'h01;
  localparam logic [7:0] RST_YEAR    = 8'h00;

  // periodic cycle select encodings
  localparam logic [2:0] PER_OFF     = 3'h0;
  localparam logic [2:0] PER_LOW     = 3'h1;
  localparam logic [2:0] PER_2HZ     = 3'h2;
  localparam logic [2:0] PER_1HZ     = 3'h3;
  localparam logic [2:0] PER_SEC     = 3'h4;
  localparam logic [2:0] PER_MIN     = 3'h5;
  localparam logic [2:0] PER_HOUR    = 3'h6;
  localparam logic [2:0] PER_MONTH   = 3'h7;

  // prescaler terminal counts and quarter-second points per crystal
  localparam logic [14:0] TERM_32768 = 15'h7fff;
  localparam logic [14:0] TERM_32000 = 15'h7cff;
  localparam logic [14:0] QTR_32768  = 15'h2000;
  localparam logic [14:0] QTR_32000  = 15'h1f40;

  // clock rate and oscillator halt timeout
  localparam int CLK_MHZ      = 100;
  localparam int HALT_US      = 100;
  localparam int HALT_CYCLES  = HALT_US * CLK_MHZ;
  // the seconds adjust completes one clock after the write, far inside the limit
  localparam int ADJ_LIMIT_NS = 122000;
  localparam int ADJ_CYCLES   = ADJ_LIMIT_NS / (1000 / CLK_MHZ);
endpackage : rtck_pkg

// ===== rtl/rtck_xtal_sense.sv
// crystal clock synchroniser, edge finder and oscillator halt detector
`timescale 1ns/1ps
module rtck_xtal_sense
  import rtck_pkg::*;
#(
  parameter int HALT_LIMIT = HALT_CYCLES
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic xtalClk,
  output logic      xtalLevel,
  output logic      xtalRise,
  output logic      oscHalted
);
  logic        syncA_r;
  logic        syncB_r;
  logic        prev_r;
  logic [15:0] idle_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      syncA_r <= 1'b0;
      syncB_r <= 1'b0;
      prev_r  <= 1'b0;
    end
    else
    begin
      syncA_r <= xtalClk;
      syncB_r <= syncA_r;
      prev_r  <= syncB_r;
    end
  end

  assign xtalLevel = syncB_r;
  assign xtalRise  = syncB_r & ~prev_r;

  // the idle count saturates so a stopped crystal keeps the halt level
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      idle_r <= 16'h0000;
    else if (xtalRise)
      idle_r <= 16'h0000;
    else if (idle_r != 16'(HALT_LIMIT))
      idle_r <= idle_r + 16'h0001;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      oscHalted <= 1'b0;
    else
      oscHalted <= (idle_r == 16'(HALT_LIMIT));
  end
endmodule : rtck_xtal_sense

// ===== rtl/rtck_core.sv
// timekeeping core: bcd time and calendar chain, control_two behaviour, interrupt pins
// Function
// - 12-hour pm hours carry pm bit, noon 32
// - adjust clears prescaler, seconds to 00
// - adjust at 30..59 seconds also increments minute
// - adjust completes within 122/125 us
// - adjust bit write-only, reads halt flag
// - halt flag set on stop, sticky
// - halt flag forces control bits to zero, format bit excepted
// - halted: pin a silent, pin b clock
// - control_two write while running clears halt flag
// - clock output disable bit gates crystal clock
// - periodic flag mirrors periodic output low
// - level mode: writing 0 clears periodic flag
// - alarm flag sets on match when enabled
// - writing 0 clears alarm flag, 1 ignored
// - disabled alarm never fires, reads 0
// - seconds bcd 00..59, carry into minutes
// - minutes bcd 00..59, carry into hours
// - hour rollover carries day and weekday
// - weekday counts 0..6; host never writes 7
// - month 1..12, wraps carrying year
// - year 00..99, multiples of four leap
// - format bit: 0 12-hour, 1 24-hour
`timescale 1ns/1ps
module rtck_core
  import rtck_pkg::*;
#(
  parameter int HALT_LIMIT = HALT_CYCLES
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       xtalClk,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  output logic            irqPinAOut,
  output logic            irqPinAOe,
  output logic            irqPinBOut,
  output logic            irqPinBOe
);
  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      return {v[7:4] + 4'h1, 4'h0};
    else
      return {v[7:4], v[3:0] + 4'h1};
  endfunction : bcdInc

  function automatic logic isLeap(input logic [7:0] y);
    if (y[4])
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction : isLeap

  function automatic logic [7:0] monthLen(input logic [7:0] m, input logic leap);
    if (m == 8'h02)
      return leap ? 8'h29 : 8'h28;
    else if ((m == 8'h04) || (m == 8'h06) || (m == 8'h09) || (m == 8'h11))
      return 8'h30;
    else
      return 8'h31;
  endfunction : monthLen

  logic        xtalLevel;
  logic        xtalRise;
  logic        oscHalted;

  logic [7:0]  sec_r, min_r, hour_r, day_r, month_r, year_r;
  logic [2:0]  weekday_r;
  logic [7:0]  secNxt, minNxt, hourNxt, dayNxt, monthNxt, yearNxt;
  logic [2:0]  weekdayNxt;
  logic        minStep, hourStep, dayStep, monthStep, yearStep;
  logic [14:0] presc_r;
  logic        secTick;
  logic        adjustReq;

  logic        haltFlag_r;
  logic        fmt24_r;
  logic        clkDis_r;
  logic        xtalSel_r;
  logic [6:0]  trimValue_r;
  logic [2:0]  perSel_r;
  logic        alEn_r [2];
  logic        routeHi_r, routeLo_r, test_r;
  logic [6:0]  alMin_r [2];
  logic [5:0]  alHour_r [2];
  logic [6:0]  alWday_r [2];
  logic        alFlag_r [2];
  logic        perFlag_r;
  logic        perLow;
  logic        perEvent;
  logic [14:0] term, quarter;
  logic        wrTwo;
  logic [7:0]  hour12Inc;

  rtck_xtal_sense #(
    .HALT_LIMIT (HALT_LIMIT)
  ) u_sense (
    .clk       (clk),
    .rst       (rst),
    .xtalClk   (xtalClk),
    .xtalLevel (xtalLevel),
    .xtalRise  (xtalRise),
    .oscHalted (oscHalted)
  );

  assign wrTwo     = regWrEn && (regAddr == ADDR_CTRL_TWO);
  assign adjustReq = wrTwo && regWrData[BIT_ADJUST];
  assign term      = xtalSel_r ? TERM_32000 : TERM_32768;
  assign quarter   = xtalSel_r ? QTR_32000 : QTR_32768;
  assign secTick   = xtalRise && (presc_r == term);
  assign hour12Inc = bcdInc({3'b000, hour_r[4:0]});

  // adjust takes effect at the next edge, well inside the 122 us bound
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      presc_r <= 15'h0000;
    else if (adjustReq)
      presc_r <= 15'h0000;
    else if (secTick)
      presc_r <= 15'h0000;
    else if (xtalRise)
      presc_r <= presc_r + 15'h0001;
  end

  always_comb
  begin
    secNxt     = sec_r;
    minNxt     = min_r;
    hourNxt    = hour_r;
    weekdayNxt = weekday_r;
    dayNxt     = day_r;
    monthNxt   = month_r;
    yearNxt    = year_r;
    minStep    = 1'b0;
    hourStep   = 1'b0;
    dayStep    = 1'b0;
    monthStep  = 1'b0;
    yearStep   = 1'b0;
    if (adjustReq)
    begin
      secNxt  = 8'h00;
      minStep = (sec_r >= 8'h30);
    end
    else if (secTick)
    begin
      if (sec_r == 8'h59)
      begin
        secNxt  = 8'h00;
        minStep = 1'b1;
      end
      else
        secNxt = bcdInc(sec_r);
    end
    if (minStep)
    begin
      if (min_r == 8'h59)
      begin
        minNxt   = 8'h00;
        hourStep = 1'b1;
      end
      else
        minNxt = bcdInc(min_r);
    end
    if (hourStep)
    begin
      if (fmt24_r)
      begin
        if (hour_r == 8'h23)
        begin
          hourNxt = 8'h00;
          dayStep = 1'b1;
        end
        else
          hourNxt = bcdInc(hour_r);
      end
      else if (hour_r[4:0] == 5'h12)
        hourNxt = {2'b00, hour_r[BIT_PM], 5'h01};
      else if (hour_r[4:0] == 5'h11)
      begin
        hourNxt = hour_r[BIT_PM] ? 8'h12 : 8'h32;
        dayStep = hour_r[BIT_PM];
      end
      else
        hourNxt = {2'b00, hour_r[BIT_PM], hour12Inc[4:0]};
    end
    if (dayStep)
    begin
      weekdayNxt = (weekday_r == 3'h6) ? 3'h0 : weekday_r + 3'h1;
      if (day_r == monthLen(month_r, isLeap(year_r)))
      begin
        dayNxt    = 8'h01;
        monthStep = 1'b1;
      end
      else
        dayNxt = bcdInc(day_r);
    end
    if (monthStep)
    begin
      if (month_r == 8'h12)
      begin
        monthNxt = 8'h01;
        yearStep = 1'b1;
      end
      else
        monthNxt = bcdInc(month_r);
    end
    if (yearStep)
      yearNxt = (year_r == 8'h99) ? 8'h00 : bcdInc(year_r);
  end

  // a host write to a counter wins over the count of the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sec_r     <= RST_SEC;
      min_r     <= RST_MIN;
      hour_r    <= RST_HOUR;
      weekday_r <= RST_WEEKDAY;
      day_r     <= RST_DAY;
      month_r   <= RST_MONTH;
      year_r    <= RST_YEAR;
    end
    else
    begin
      sec_r     <= (regWrEn && regAddr == ADDR_SEC) ? {1'b0, regWrData[6:0]} : secNxt;
      min_r     <= (regWrEn && regAddr == ADDR_MIN) ? {1'b0, regWrData[6:0]} : minNxt;
      hour_r    <= (regWrEn && regAddr == ADDR_HOUR) ? {2'b00, regWrData[5:0]} : hourNxt;
      weekday_r <= (regWrEn && regAddr == ADDR_WEEKDAY) ? regWrData[2:0] : weekdayNxt;
      day_r     <= (regWrEn && regAddr == ADDR_DAY) ? {2'b00, regWrData[5:0]} : dayNxt;
      month_r   <= (regWrEn && regAddr == ADDR_MONTH) ? {3'b000, regWrData[4:0]} : monthNxt;
      year_r    <= (regWrEn && regAddr == ADDR_YEAR) ? regWrData : yearNxt;
    end
  end

  // powers up set; a halt sensed in the write cycle beats the clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      haltFlag_r <= 1'b1;
    else if (oscHalted)
      haltFlag_r <= 1'b1;
    else if (wrTwo)
      haltFlag_r <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fmt24_r <= 1'b0;
    else if (wrTwo)
      fmt24_r <= regWrData[BIT_FMT24];
  end

  // the control_two write that clears the halt flag also lands its disable bit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      clkDis_r <= 1'b0;
    else if (wrTwo && !oscHalted)
      clkDis_r <= regWrData[BIT_CLKDIS];
    else if (haltFlag_r || oscHalted)
      clkDis_r <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      xtalSel_r   <= 1'b0;
      trimValue_r <= 7'h00;
      perSel_r    <= PER_OFF;
      alEn_r[0]   <= 1'b0;
      alEn_r[1]   <= 1'b0;
      routeHi_r   <= 1'b0;
      routeLo_r   <= 1'b0;
      test_r      <= 1'b0;
    end
    // forcing on the sensing cycle too, so no read sees the flag set with stale bits
    else if (haltFlag_r || oscHalted)
    begin
      xtalSel_r   <= 1'b0;
      trimValue_r <= 7'h00;
      perSel_r    <= PER_OFF;
      alEn_r[0]   <= 1'b0;
      alEn_r[1]   <= 1'b0;
      routeHi_r   <= 1'b0;
      routeLo_r   <= 1'b0;
      test_r      <= 1'b0;
    end
    else if (regWrEn && regAddr == ADDR_TRIM)
    begin
      xtalSel_r   <= regWrData[BIT_XSEL];
      trimValue_r <= regWrData[6:0];
    end
    else if (regWrEn && regAddr == ADDR_CTRL_ONE)
    begin
      alEn_r[0] <= regWrData[BIT_AEN];
      alEn_r[1] <= regWrData[BIT_BEN];
      routeHi_r <= regWrData[BIT_ROUTEHI];
      routeLo_r <= regWrData[BIT_ROUTELO];
      test_r    <= regWrData[BIT_TEST];
      perSel_r  <= regWrData[2:0];
    end
  end

  // alarm compare registers; each alarm owns three consecutive addresses
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 2; i++)
      begin
        alMin_r[i]  <= 7'h00;
        alHour_r[i] <= 6'h00;
        alWday_r[i] <= 7'h00;
      end
    end
    else if (regWrEn)
    begin
      if (regAddr == ADDR_ALA_MIN)
        alMin_r[0] <= regWrData[6:0];
      else if (regAddr == ADDR_ALA_HOUR)
        alHour_r[0] <= regWrData[5:0];
      else if (regAddr == ADDR_ALA_WDAY)
        alWday_r[0] <= regWrData[6:0];
      else if (regAddr == ADDR_ALB_MIN)
        alMin_r[1] <= regWrData[6:0];
      else if (regAddr == ADDR_ALB_HOUR)
        alHour_r[1] <= regWrData[5:0];
      else if (regAddr == ADDR_ALB_WDAY)
        alWday_r[1] <= regWrData[6:0];
    end
  end

  // matches are checked only when the minute moves, so one hit per minute
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      alFlag_r[0] <= 1'b0;
      alFlag_r[1] <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!alEn_r[i])
          alFlag_r[i] <= 1'b0;
        else if (minStep && minNxt[6:0] == alMin_r[i] && hourNxt[5:0] == alHour_r[i]
                 && alWday_r[i][weekdayNxt])
          alFlag_r[i] <= 1'b1;
        else if (wrTwo && !regWrData[i == 0 ? BIT_AFLAG : BIT_BFLAG])
          alFlag_r[i] <= 1'b0;
      end
    end
  end

  always_comb
  begin
    case (perSel_r)
      PER_SEC:   perEvent = adjustReq || secTick;
      PER_MIN:   perEvent = minStep;
      PER_HOUR:  perEvent = hourStep;
      PER_MONTH: perEvent = monthStep;
      default:   perEvent = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      perFlag_r <= 1'b0;
    else if (!perSel_r[2])
      perFlag_r <= 1'b0;
    else if (perEvent)
      perFlag_r <= 1'b1;
    else if (wrTwo && !regWrData[BIT_PERFLAG])
      perFlag_r <= 1'b0;
  end

  always_comb
  begin
    case (perSel_r)
      PER_OFF: perLow = 1'b0;
      PER_LOW: perLow = 1'b1;
      PER_2HZ: perLow = (presc_r < quarter) || ((presc_r >= (quarter << 1)) && (presc_r < quarter * 15'd3));
      PER_1HZ: perLow = (presc_r < (quarter << 1));
      default: perLow = perFlag_r;
    endcase
  end

  // open-drain pins: out stays low, enable pulls the wire
  assign irqPinAOut = 1'b0;
  assign irqPinBOut = 1'b0;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irqPinAOe <= 1'b0;
      irqPinBOe <= 1'b0;
    end
    else
    begin
      irqPinAOe <= !haltFlag_r && (alFlag_r[0] || (alFlag_r[1] && !routeLo_r)
                   || (perLow && !routeHi_r));
      irqPinBOe <= (!clkDis_r && !xtalLevel) || (alFlag_r[1] && routeLo_r)
                   || (perLow && routeHi_r);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      regRdData <= 8'h00;
    else if (regRdEn)
    begin
      if (regAddr == ADDR_SEC)
        regRdData <= sec_r;
      else if (regAddr == ADDR_MIN)
        regRdData <= min_r;
      else if (regAddr == ADDR_HOUR)
        regRdData <= hour_r;
      else if (regAddr == ADDR_WEEKDAY)
        regRdData <= {5'h00, weekday_r};
      else if (regAddr == ADDR_DAY)
        regRdData <= day_r;
      else if (regAddr == ADDR_MONTH)
        regRdData <= month_r;
      else if (regAddr == ADDR_YEAR)
        regRdData <= year_r;
      else if (regAddr == ADDR_TRIM)
        regRdData <= {xtalSel_r, trimValue_r};
      else if (regAddr == ADDR_ALA_MIN)
        regRdData <= {1'b0, alMin_r[0]};
      else if (regAddr == ADDR_ALA_HOUR)
        regRdData <= {2'b00, alHour_r[0]};
      else if (regAddr == ADDR_ALA_WDAY)
        regRdData <= {1'b0, alWday_r[0]};
      else if (regAddr == ADDR_ALB_MIN)
        regRdData <= {1'b0, alMin_r[1]};
      else if (regAddr == ADDR_ALB_HOUR)
        regRdData <= {2'b00, alHour_r[1]};
      else if (regAddr == ADDR_ALB_WDAY)
        regRdData <= {1'b0, alWday_r[1]};
      else if (regAddr == ADDR_CTRL_ONE)
        regRdData <= {alEn_r[0], alEn_r[1], routeHi_r, routeLo_r, test_r, perSel_r};
      else
        regRdData <= {2'b00, fmt24_r, haltFlag_r, clkDis_r, perLow,
                      alFlag_r[0] && alEn_r[0], alFlag_r[1] && alEn_r[1]};
    end
  end
endmodule : rtck_core

// ===== tb/rtck_core_props.sv
// register port properties of the timekeeping core
`timescale 1ns/1ps
module rtck_core_props
  import rtck_pkg::*;
#(
  parameter int HALT_LIMIT = HALT_CYCLES
)
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_rd(logic [3:0] a);
    regRdEn && regAddr == a;
  endsequence
  sequence s_adj;
    regWrEn && regAddr == ADDR_CTRL_TWO && regWrData[BIT_ADJUST];
  endsequence
  sequence s_alm_off;
    regWrEn && regAddr == ADDR_CTRL_ONE && regWrData[7:6] == 2'b00;
  endsequence

  a_adj_sec_zero: assert property (s_adj ##1 s_rd(ADDR_SEC) |=> regRdData == 8'h00)
    else $error("seconds not cleared by adjust");
  a_sec_written: assert property (regWrEn && regAddr == ADDR_SEC ##1 s_rd(ADDR_SEC)
    |=> regRdData == ($past(regWrData, 2) & 8'h7f))
    else $error("seconds differ from value written");
  a_sec_bcd: assert property (s_rd(ADDR_SEC) |=> !regRdData[7] && regRdData[6:4] <= 3'h5
    && regRdData[3:0] <= 4'h9)
    else $error("seconds out of range");
  a_min_bcd: assert property (s_rd(ADDR_MIN) |=> !regRdData[7] && regRdData[6:4] <= 3'h5
    && regRdData[3:0] <= 4'h9)
    else $error("minutes out of range");
  a_hour_bcd: assert property (s_rd(ADDR_HOUR) |=> regRdData[7:6] == 2'b00 && regRdData[3:0] <= 4'h9)
    else $error("hours out of range");
  a_wday_range: assert property (s_rd(ADDR_WEEKDAY) |=> regRdData <= 8'h06)
    else $error("weekday out of range");
  a_day_range: assert property (s_rd(ADDR_DAY) |=> regRdData inside {[8'h01:8'h31]}
    && regRdData[3:0] <= 4'h9)
    else $error("day out of range");
  a_month_range: assert property (s_rd(ADDR_MONTH) |=> regRdData inside {[8'h01:8'h12]}
    && regRdData[3:0] <= 4'h9)
    else $error("month out of range");
  a_year_bcd: assert property (s_rd(ADDR_YEAR) |=> regRdData[7:4] <= 4'h9 && regRdData[3:0] <= 4'h9)
    else $error("year not bcd");
  a_alarm_off: assert property (s_alm_off ##1 s_rd(ADDR_CTRL_TWO) |=> regRdData[1:0] == 2'b00)
    else $error("alarm flag readable while disabled");
endmodule : rtck_core_props

// ===== tb/rtck_xtal_model.sv
// crystal oscillator stand-in that can be stopped to provoke halt sensing
`timescale 1ns/1ps
module rtck_xtal_model
(
  input  wire logic run,
  output logic      xtalClk
);
  initial xtalClk = 1'b0;
  // a stopped crystal rests low; the 13 ns skew keeps it unrelated to clk
  always
  begin
    #13;
    forever
    begin
      #40;
      xtalClk = run ? ~xtalClk : 1'b0;
    end
  end
endmodule : rtck_xtal_model

// ===== tb/rtck_core_test.sv
// self-checking bench: calendar carry table, flags, clock output and halt sensing
`timescale 1ns/1ps
module rtck_core_test
  import rtck_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         xtalRun = 1'b1;
  logic         xtalClk;
  logic         regWrEn = 1'b0;
  logic         regRdEn = 1'b0;
  logic [3:0]   regAddr = 4'h0;
  logic [7:0]   regWrData = 8'h00;
  logic [7:0]   regRdData;
  logic         irqPinAOe;
  logic         irqPinAOut;
  logic         irqPinBOut;
  logic         irqPinBOe;
  logic [7:0]   rdv;
  int           n;
  int           num_errors = 0;
  int           comparisons = 0;
  // ctl sec min hour wday day month year, then expected min hour wday day month year
  logic [111:0] tbl [8] = '{
    112'h2015100502140307100502140307, 112'h2030592306280204000000290204,
    112'h2059592302280203000003010303, 112'h2045592300311299000001010100,
    112'h2050592304300421000005010521, 112'h0040591101050610003201050610,
    112'h0040593201050610002101050610, 112'h0040593104050610001205060610};

  always #5 clk = ~clk;

  rtck_xtal_model xtal (.run(xtalRun), .xtalClk(xtalClk));

  rtck_core #(.HALT_LIMIT(40)) dut (.clk(clk), .rst(rst), .xtalClk(xtalClk), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .irqPinAOut(irqPinAOut), .irqPinAOe(irqPinAOe), .irqPinBOut(irqPinBOut), .irqPinBOe(irqPinBOe));

  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // a write leaves the strobe up; the next task drops it, so writes may run back to back
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    {regRdEn, regWrEn, regAddr, regWrData} = {1'b0, 1'b1, a, d};
  endtask : wr

  task rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    {regWrEn, regRdEn, regAddr} = {1'b0, 1'b1, a};
    @(negedge clk);
    regRdEn = 1'b0;
    d = regRdData;
  endtask : rd

  task rdchk(input logic [3:0] a, input logic [7:0] exp);
    rd(a, rdv);
    chk(rdv, exp);
  endtask : rdchk

  task chka(input logic e);
    chk({7'h0, irqPinAOe}, {7'h0, e});
  endtask : chka

  // counts cycles with pin b pulled low over a window of two crystal periods
  task pinb(input logic e);
    @(negedge clk);
    regWrEn = 1'b0;
    n = 0;
    repeat (16)
    begin
      @(negedge clk);
      if (irqPinBOe === 1'b1)
        n++;
    end
    chk({7'h0, n > 0}, {7'h0, e});
  endtask : pinb

  task done(input string s);
    $display("test %s finished, %0d mismatches so far", s, num_errors);
  endtask : done

  task end_of_test;
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rdchk(ADDR_CTRL_TWO, 8'h10);
    rdchk(ADDR_HOUR, RST_HOUR);
    chka(1'b0);
    chk({6'h00, irqPinAOut, irqPinBOut}, 8'h00);
    pinb(1'b1);
    wr(ADDR_CTRL_TWO, 8'h27);
    rdchk(ADDR_CTRL_TWO, 8'h20);
    done("reset_halt");
    wr(ADDR_SEC, 8'h37);
    rdchk(ADDR_SEC, 8'h37);
    for (int i = 0; i < 8; i++)
    begin
      wr(ADDR_CTRL_TWO, tbl[i][111 -: 8] | 8'h07);
      for (int k = 1; k < 8; k++)
        wr(4'(k - 1), tbl[i][8 * (13 - k) +: 8]);
      wr(ADDR_CTRL_TWO, tbl[i][111 -: 8] | 8'h17);
      rdchk(ADDR_SEC, 8'h00);
      for (int k = 0; k < 6; k++)
        rdchk(4'(k + 1), tbl[i][8 * (5 - k) +: 8]);
    end
    done("carry_table");
    wr(ADDR_CTRL_ONE, {5'h0, PER_LOW});
    rdchk(ADDR_CTRL_TWO, 8'h04);
    chka(1'b1);
    wr(ADDR_CTRL_TWO, 8'h03);
    rdchk(ADDR_CTRL_TWO, 8'h04);
    wr(ADDR_CTRL_ONE, {5'h0, PER_2HZ});
    rdchk(ADDR_CTRL_TWO, 8'h04);
    wr(ADDR_CTRL_ONE, {5'h0, PER_1HZ});
    rdchk(ADDR_CTRL_TWO, 8'h04);
    wr(ADDR_CTRL_ONE, {5'h0, PER_SEC});
    wr(ADDR_CTRL_TWO, 8'h37);
    rdchk(ADDR_CTRL_TWO, 8'h24);
    chka(1'b1);
    wr(ADDR_CTRL_TWO, 8'h23);
    rdchk(ADDR_CTRL_TWO, 8'h20);
    chka(1'b0);
    done("periodic");
    wr(ADDR_CTRL_ONE, 8'h80);
    wr(ADDR_ALA_MIN, 8'h05);
    wr(ADDR_ALA_HOUR, 8'h10);
    wr(ADDR_ALA_WDAY, 8'h7f);
    wr(ADDR_HOUR, 8'h10);
    wr(ADDR_MIN, 8'h04);
    wr(ADDR_SEC, 8'h40);
    wr(ADDR_CTRL_TWO, 8'h37);
    rdchk(ADDR_CTRL_TWO, 8'h22);
    chka(1'b1);
    wr(ADDR_CTRL_TWO, 8'h27);
    rdchk(ADDR_CTRL_TWO, 8'h22);
    wr(ADDR_CTRL_TWO, 8'h25);
    rdchk(ADDR_CTRL_TWO, 8'h20);
    chka(1'b0);
    wr(ADDR_MIN, 8'h04);
    wr(ADDR_SEC, 8'h40);
    wr(ADDR_CTRL_TWO, 8'h37);
    rdchk(ADDR_CTRL_TWO, 8'h22);
    wr(ADDR_CTRL_ONE, 8'h00);
    rdchk(ADDR_CTRL_TWO, 8'h20);
    done("alarm");
    wr(ADDR_CTRL_TWO, 8'h2f);
    pinb(1'b0);
    wr(ADDR_CTRL_TWO, 8'h27);
    pinb(1'b1);
    done("clock_out");
    wr(ADDR_TRIM, 8'h85);
    wr(ADDR_CTRL_ONE, 8'hf8);
    wr(ADDR_CTRL_TWO, 8'h2f);
    rdchk(ADDR_CTRL_ONE, 8'hf8);
    xtalRun = 1'b0;
    rdv = 8'h00;
    for (int i = 0; i < 50 && rdv[4] !== 1'b1; i++)
      rd(ADDR_CTRL_TWO, rdv);
    if (rdv[4] !== 1'b1)
    begin
      num_errors++;
      $display("Error at %0t ns: oscillator stop never sensed", $time);
      end_of_test;
    end
    chk(rdv, 8'h30);
    rdchk(ADDR_TRIM, 8'h00);
    rdchk(ADDR_CTRL_ONE, 8'h00);
    chka(1'b0);
    xtalRun = 1'b1;
    pinb(1'b1);
    rdchk(ADDR_CTRL_TWO, 8'h30);
    wr(ADDR_CTRL_TWO, 8'h27);
    rdchk(ADDR_CTRL_TWO, 8'h20);
    done("halt");
    end_of_test;
  end
endmodule : rtck_core_test

bind rtck_core rtck_core_props #(.HALT_LIMIT(HALT_LIMIT)) props (.clk(clk), .rst(rst), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));
